// File: verilog/scan_map.vh
`ifndef SCAN_MAP_VH
`define SCAN_MAP_VH

// instruction register layout and codes
`define IR_W          3
`define INS_EXTEST    3'h0
`define INS_IDCODE    3'h1
`define INS_SAMPLE_Z  3'h2
`define INS_SAMPLE    3'h4
`define INS_BYPASS    3'h7
// capture-ir pattern: fixed low pair plus an upper bit
`define IR_CAPT_LO    2'h1
`define IR_CAPT_HI    1'h0

// identification register, value is arbitrary (lsb must be one)
`define ID_W          32
`define ID_CODE       32'h0a5a_c001

// bypass capture value
`define BYP_CAPT      1'h0

// boundary ring: length and the output-bus enable cell
`define BSR_LEN       109
`define OE_CELL       108
`define OE_PRESET     1'h1

// tap controller state vector width (one-hot)
`define ST_W          16

`endif

// File: verilog/pin_sync.v
`timescale 1ns/10ps

// three-stage synchroniser; output moves only when stages two and three agree
module pin_sync #(
  parameter       WIDTH = 1,
  parameter [0:0] INIT  = 1'h0
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst_b,
  // asynchronous pins and the filtered level
  input  wire [WIDTH-1:0] pin,
  output reg  [WIDTH-1:0] level_r
);

  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;

  // s1 is read only by s2, so no logic sees a metastable value
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r    <= {WIDTH{INIT}};
      s2_r    <= {WIDTH{INIT}};
      s3_r    <= {WIDTH{INIT}};
      level_r <= {WIDTH{INIT}};
    end else begin
      s1_r    <= pin;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= (s2_r & s3_r) | (level_r & (s2_r ^ s3_r));
    end
  end

endmodule

// File: verilog/scan_reg.v
`timescale 1ns/10ps

// scan shift stage with a parallel update latch behind it
module scan_reg #(
  parameter             WIDTH    = 3,
  parameter [WIDTH-1:0] UPD_INIT = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst_b,
  // one-cycle strokes from the controller; preset is a level held through test-logic-reset
  input  wire             capture,
  input  wire             shift,
  input  wire             update,
  input  wire             preset,
  // serial and parallel data
  input  wire             si,
  input  wire [WIDTH-1:0] par_in,
  output wire             so,
  output reg  [WIDTH-1:0] upd_r
);

  reg [WIDTH-1:0] sh_r;

  // msb faces serial in, lsb faces serial out
  assign so = sh_r[0];

  // shift stage: capture beats shift, they never coincide anyway
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_r <= {WIDTH{1'b0}};
    end else if (capture) begin
      sh_r <= par_in;
    end else if (shift) begin
      sh_r <= {si, sh_r[WIDTH-1:1]};
    end
  end

  // update latch: test reset preset wins over an update
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      upd_r <= UPD_INIT;
    end else if (preset) begin
      upd_r <= UPD_INIT;
    end else if (update) begin
      upd_r <= sh_r;
    end
  end

endmodule

// File: verilog/boundary_scan_tap.v
`timescale 1ns/10ps
`include "scan_map.vh"

module boundary_scan_tap #(
  parameter            BSR_LEN = `BSR_LEN,
  parameter [`ID_W-1:0] ID_CODE = `ID_CODE
) (
  // core clock and power-up reset
  input  wire               core_clk,
  input  wire               rst_b,
  // test pins from the board controller
  input  wire               tck,
  input  wire               tms,
  input  wire               tdi,
  output reg                tdo,
  output reg                tdo_oe,
  // pin ring as seen at the bumps
  input  wire [BSR_LEN-1:0] ring_in,
  // functional drive from the memory core
  input  wire [BSR_LEN-1:0] func_out,
  input  wire               func_oe,
  // drive toward the bumps
  output reg  [BSR_LEN-1:0] pin_out,
  output reg                q_oe,
  // test status
  output wire               test_reset,
  output wire               extest_on
);

  // one-hot controller states
  localparam [`ST_W-1:0] ST_TLR    = 16'h0001;
  localparam [`ST_W-1:0] ST_RTI    = 16'h0002;
  localparam [`ST_W-1:0] ST_SEL_DR = 16'h0004;
  localparam [`ST_W-1:0] ST_CAP_DR = 16'h0008;
  localparam [`ST_W-1:0] ST_SH_DR  = 16'h0010;
  localparam [`ST_W-1:0] ST_EX1_DR = 16'h0020;
  localparam [`ST_W-1:0] ST_PA_DR  = 16'h0040;
  localparam [`ST_W-1:0] ST_EX2_DR = 16'h0080;
  localparam [`ST_W-1:0] ST_UP_DR  = 16'h0100;
  localparam [`ST_W-1:0] ST_SEL_IR = 16'h0200;
  localparam [`ST_W-1:0] ST_CAP_IR = 16'h0400;
  localparam [`ST_W-1:0] ST_SH_IR  = 16'h0800;
  localparam [`ST_W-1:0] ST_EX1_IR = 16'h1000;
  localparam [`ST_W-1:0] ST_PA_IR  = 16'h2000;
  localparam [`ST_W-1:0] ST_EX2_IR = 16'h4000;
  localparam [`ST_W-1:0] ST_UP_IR  = 16'h8000;

  // update-latch preset: only the bus enable cell starts high
  localparam [BSR_LEN-1:0] BSR_INIT = {{(BSR_LEN-1){1'b0}}, `OE_PRESET} << `OE_CELL;

  // controller transition table
  function [`ST_W-1:0] next_state;
    input [`ST_W-1:0] cur;
    input             mode;
    begin
      case (cur)
        ST_TLR:    next_state = mode ? ST_TLR    : ST_RTI;
        ST_RTI:    next_state = mode ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR: next_state = mode ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: next_state = mode ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  next_state = mode ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: next_state = mode ? ST_UP_DR  : ST_PA_DR;
        ST_PA_DR:  next_state = mode ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: next_state = mode ? ST_UP_DR  : ST_SH_DR;
        ST_UP_DR:  next_state = mode ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR: next_state = mode ? ST_TLR    : ST_CAP_IR;
        ST_CAP_IR: next_state = mode ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  next_state = mode ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: next_state = mode ? ST_UP_IR  : ST_PA_IR;
        ST_PA_IR:  next_state = mode ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: next_state = mode ? ST_UP_IR  : ST_SH_IR;
        ST_UP_IR:  next_state = mode ? ST_SEL_DR : ST_RTI;
        default:   next_state = ST_TLR;
      endcase
    end
  endfunction

  // instructions that put the boundary ring on the serial path
  function ins_bsr;
    input [`IR_W-1:0] ins;
    begin
      ins_bsr = (ins == `INS_EXTEST) || (ins == `INS_SAMPLE) || (ins == `INS_SAMPLE_Z);
    end
  endfunction

  // synchronised test pins
  wire               tck_s;
  wire               tms_s;
  wire               tdi_s;
  wire [BSR_LEN-1:0] ring_s;

  // controller and edge tracking
  reg  [`ST_W-1:0]   state_r;
  reg  [`ST_W-1:0]   state_nxt;
  reg                tck_d_r;
  wire               tck_rise;
  wire               tck_fall;

  // register strokes
  wire               in_tlr;
  wire               sel_bsr;
  wire               sel_id;
  wire               ir_cap;
  wire               ir_shift;
  wire               ir_upd;
  wire               bsr_cap;
  wire               bsr_shift;
  wire               bsr_upd_stb;
  wire               dr_cap;
  wire               dr_shift;

  // register contents
  wire [`IR_W-1:0]   ins_cur;
  wire               ir_so;
  wire [BSR_LEN-1:0] bsr_upd;
  wire               bsr_so;
  reg  [`ID_W-1:0]   id_r;
  reg  [`ID_W-1:0]   id_nxt;
  reg                byp_r;
  reg                byp_nxt;
  reg                lsb_sel;

  // tck is sampled like any pin; mode select and data in idle high as if pulled up
  pin_sync #(
    .WIDTH (1),
    .INIT  (1'h0)
  ) u_tck_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin      (tck),
    .level_r  (tck_s)
  );

  pin_sync #(
    .WIDTH (2),
    .INIT  (1'h1)
  ) u_ctl_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin      ({tms, tdi}),
    .level_r  ({tms_s, tdi_s})
  );

  // ring values change on the memory clock; a cell caught mid-edge may read either way
  pin_sync #(
    .WIDTH (BSR_LEN),
    .INIT  (1'h0)
  ) u_ring_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin      (ring_in),
    .level_r  (ring_s)
  );

  // edge finder on the filtered test clock
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;

  // next state only on a test clock rise, using mode select as sampled there
  always @* begin
    state_nxt = state_r;
    if (tck_rise) begin
      state_nxt = next_state(state_r, tms_s);
    end
  end

  // power-up lands in test-logic-reset; five high mode selects get there from anywhere
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // decode of the current state and instruction
  assign in_tlr    = (state_r == ST_TLR);
  assign sel_bsr   = ins_bsr(ins_cur);
  assign sel_id    = (ins_cur == `INS_IDCODE);
  assign test_reset = in_tlr;
  assign extest_on  = (ins_cur == `INS_EXTEST);

  // captures and shifts act on the rise in their state, updates on the fall
  assign ir_cap      = tck_rise & (state_r == ST_CAP_IR);
  assign ir_shift    = tck_rise & (state_r == ST_SH_IR);
  assign ir_upd      = tck_fall & (state_r == ST_UP_IR);
  assign bsr_cap     = tck_rise & (state_r == ST_CAP_DR) & sel_bsr;
  assign bsr_shift   = tck_rise & (state_r == ST_SH_DR) & sel_bsr;
  assign bsr_upd_stb = tck_fall & (state_r == ST_UP_DR) & sel_bsr;

  // data strokes shared by the identify and bypass paths
  assign dr_cap   = tck_rise & (state_r == ST_CAP_DR);
  assign dr_shift = tck_rise & (state_r == ST_SH_DR);

  // instruction register: three bits, preset to identify in test-logic-reset
  scan_reg #(
    .WIDTH    (`IR_W),
    .UPD_INIT (`INS_IDCODE)
  ) u_ir (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .capture  (ir_cap),
    .shift    (ir_shift),
    .update   (ir_upd),
    .preset   (in_tlr),
    .si       (tdi_s),
    .par_in   ({`IR_CAPT_HI, `IR_CAPT_LO}),
    .so       (ir_so),
    .upd_r    (ins_cur)
  );

  // boundary ring: cell 0 faces data out, the top cell faces data in
  scan_reg #(
    .WIDTH    (BSR_LEN),
    .UPD_INIT (BSR_INIT)
  ) u_bsr (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .capture  (bsr_cap),
    .shift    (bsr_shift),
    .update   (bsr_upd_stb),
    .preset   (in_tlr),
    .si       (tdi_s),
    .par_in   (ring_s),
    .so       (bsr_so),
    .upd_r    (bsr_upd)
  );

  // identification register: hardwired code, loaded only under identify
  always @* begin
    id_nxt = id_r;
    if (dr_cap && sel_id) begin
      id_nxt = ID_CODE;
    end else if (dr_shift && sel_id) begin
      id_nxt = {tdi_s, id_r[`ID_W-1:1]};
    end
  end

  // identify stage loads every core clock, holding by its next value
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      id_r <= {`ID_W{1'b0}};
    end else begin
      id_r <= id_nxt;
    end
  end

  // bypass flop: reserved codes fall here too, so the path is always one bit long
  always @* begin
    byp_nxt = byp_r;
    if (dr_cap && !sel_bsr && !sel_id) begin
      byp_nxt = `BYP_CAPT;
    end else if (dr_shift && !sel_bsr && !sel_id) begin
      byp_nxt = tdi_s;
    end
  end

  // bypass stage loads every core clock, holding by its next value
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      byp_r <= `BYP_CAPT;
    end else begin
      byp_r <= byp_nxt;
    end
  end

  // exactly one register reaches data out: ir while shifting ir, else by instruction
  always @* begin
    if (state_r == ST_SH_IR) begin
      lsb_sel = ir_so;
    end else if (sel_bsr) begin
      lsb_sel = bsr_so;
    end else if (sel_id) begin
      lsb_sel = id_r[0];
    end else begin
      lsb_sel = byp_r;
    end
  end

  // data out moves on the falling edge and drives only in the two shift states
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= lsb_sel;
      tdo_oe <= (state_r == ST_SH_DR) || (state_r == ST_SH_IR);
    end
  end

  // pin drive: functional unless extest; registered so the bumps never glitch
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= {BSR_LEN{1'b0}};
    end else if (extest_on) begin
      pin_out <= bsr_upd;
    end else begin
      pin_out <= func_out;
    end
  end

  // output bus enable: cell 108 under extest, floated under sample-z
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_oe <= 1'b0;
    end else if (extest_on) begin
      q_oe <= bsr_upd[`OE_CELL];
    end else if (ins_cur == `INS_SAMPLE_Z) begin
      q_oe <= 1'b0;
    end else begin
      q_oe <= func_oe;
    end
  end

endmodule

// File: sim/tap_asserts.sv
`timescale 1ns/10ps
`include "scan_map.vh"

module tap_asserts #(
  parameter BSR_LEN = `BSR_LEN
) (
  // clock and reset
  input wire               core_clk,
  input wire               rst_b,
  // test pins
  input wire               tck,
  input wire               tms,
  input wire               tdi,
  input wire               tdo,
  input wire               tdo_oe,
  // pin ring and functional path
  input wire [BSR_LEN-1:0] ring_in,
  input wire [BSR_LEN-1:0] func_out,
  input wire               func_oe,
  input wire [BSR_LEN-1:0] pin_out,
  input wire               q_oe,
  // status
  input wire               test_reset,
  input wire               extest_on
);
  reg       tck_r;
  reg [3:0] fall_age_r;
  reg [3:0] rise_age_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // age of the last tck edge; saturates so a quiet link never wraps round
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_r      <= 1'h0;
      fall_age_r <= 4'hf;
      rise_age_r <= 4'hf;
    end else begin
      tck_r      <= tck;
      fall_age_r <= (tck_r && !tck) ? 4'h0 : fall_age_r + {3'h0, fall_age_r != 4'hf};
      rise_age_r <= (!tck_r && tck) ? 4'h0 : rise_age_r + {3'h0, rise_age_r != 4'hf};
    end
  end

  a_tdo_on_fall: assert property ($changed(tdo) |-> fall_age_r <= 4'h8)
    else $error("tdo moved away from a tck fall");
  a_oe_on_fall: assert property ($changed(tdo_oe) |-> fall_age_r <= 4'h8)
    else $error("tdo_oe moved away from a tck fall");
  a_state_on_rise: assert property ($changed(test_reset) |-> rise_age_r <= 4'h8)
    else $error("controller state moved away from a tck rise");
  a_ins_on_fall: assert property ($changed(extest_on) |-> fall_age_r <= 4'h8 || test_reset)
    else $error("instruction changed away from an update fall or reset");
  a_idle_no_drive: assert property (test_reset |-> !tdo_oe)
    else $error("tdo driven in reset state");
  a_reset_ins: assert property (test_reset && $past(test_reset) |-> !extest_on)
    else $error("external test active in reset state");
  a_reset_func: assert property (test_reset && $past(test_reset)
    |=> pin_out == $past(func_out) && q_oe == $past(func_oe))
    else $error("functional path disturbed in reset state");
  a_extest_cell: assert property (extest_on && $past(extest_on) |-> q_oe == pin_out[`OE_CELL])
    else $error("bus enable not following its cell");
  a_oe_gated: assert property (!extest_on && !$past(extest_on) |=> !q_oe || $past(func_oe))
    else $error("bus enabled without functional request");
endmodule

bind boundary_scan_tap tap_asserts #(.BSR_LEN(BSR_LEN)) tap_asserts_i (
  .core_clk(core_clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdo_oe(tdo_oe), .ring_in(ring_in), .func_out(func_out), .func_oe(func_oe),
  .pin_out(pin_out), .q_oe(q_oe), .test_reset(test_reset), .extest_on(extest_on));

// File: sim/jtag_ctl.sv
`timescale 1ns/10ps

module jtag_ctl (
  // link toward the port
  output reg  tck,
  output reg  tms,
  output reg  tdi,
  input  wire tdo,
  input  wire tdo_oe
);
  reg oe_seen;
  reg oe_now;

  // tck stands low between frames; tdi rests high like its pull-up
  initial begin
    tck     = 1'h0;
    tms     = 1'h1;
    tdi     = 1'h1;
    oe_seen = 1'h1;
    oe_now  = 1'h0;
  end

  // one 125 ns period; tdo is read late in the low phase since it lags the fall
  task step(input m, input d, output o);
    begin
      tms = m;
      tdi = d;
      #60;
      // nothing holds a released tdo, so it reads as the opposite of its last value
      o      = tdo_oe ? tdo : ~tdo;
      oe_now = tdo_oe;
      #2.5 tck = 1'h1;
      #62.5 tck = 1'h0;
    end
  endtask

  // full scan from idle, lsb first, back to idle through the update state
  task scan(input ir, input integer n, input [127:0] din, output [127:0] dout);
    integer i;
    reg     b;
    begin
      dout = 128'h0;
      step(1'h1, 1'h1, b);
      if (ir)
        step(1'h1, 1'h1, b);
      step(1'h0, 1'h1, b);
      step(1'h0, 1'h1, b);
      oe_seen = 1'h1;
      for (i = 0; i < n; i = i + 1) begin
        step(i == n - 1, din[i], b);
        dout[i] = b;
        oe_seen = oe_seen & oe_now;
      end
      step(1'h1, 1'h1, b);
      step(1'h0, 1'h1, b);
      #200;
    end
  endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/10ps
`include "scan_map.vh"

module tb_top;
  localparam [`BSR_LEN-1:0] RING = {1'h1, {27{4'ha}}};
  localparam [`BSR_LEN-1:0] PRE  = {1'h0, {27{4'h6}}};
  localparam [`BSR_LEN-1:0] FUNC = {1'h1, {27{4'h3}}};
  reg                 core_clk;
  reg                 rst_b;
  reg [`BSR_LEN-1:0]  ring_in;
  reg [`BSR_LEN-1:0]  func_out;
  reg                 func_oe;
  wire                tck, tms, tdi, tdo, tdo_oe, q_oe, test_reset, extest_on;
  wire [`BSR_LEN-1:0] pin_out;
  integer             fail_count;
  integer             n_checks;
  integer             i;
  reg [127:0]         d;
  reg                 b;

  boundary_scan_tap boundary_scan_tap_i (.core_clk(core_clk), .rst_b(rst_b), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .func_out(func_out), .func_oe(func_oe),
    .pin_out(pin_out), .q_oe(q_oe), .test_reset(test_reset), .extest_on(extest_on));
  jtag_ctl jtag_ctl_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  // 100 MHz core clock
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  task check(input [127:0] got, input [127:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task summarize;
    begin
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // data scan, then the drive enable must have covered the shift and dropped after it
  task dr(input integer n, input [127:0] din);
    begin
      jtag_ctl_i.scan(1'h0, n, din, d);
      check(jtag_ctl_i.oe_seen, 1'h1);
      check(jtag_ctl_i.oe_now, 1'h0);
    end
  endtask

  // instruction load; only defined codes are ever sent
  task ld_ir(input [2:0] code);
    begin
      jtag_ctl_i.scan(1'h1, 3, {125'h0, code}, d);
      check(d[2:0], {`IR_CAPT_HI, `IR_CAPT_LO});
    end
  endtask

  // five high mode selects from shift-dr; the fourth must not yet reset
  task tap_reset;
    begin
      for (i = 0; i < 3; i = i + 1)
        jtag_ctl_i.step(i == 0, 1'h1, b);
      for (i = 0; i < 5; i = i + 1) begin
        jtag_ctl_i.step(1'h1, 1'h1, b);
        #100;
        check(test_reset, i == 4);
      end
      check(extest_on, 1'h0);
      check(q_oe, func_oe);
      check(pin_out, FUNC);
      jtag_ctl_i.step(1'h0, 1'h1, b);
    end
  endtask

  task t_power;
    begin
      check(test_reset, 1'h1);
      check(tdo_oe, 1'h0);
      check(pin_out, FUNC);
      check(q_oe, 1'h1);
      jtag_ctl_i.step(1'h0, 1'h1, b);
      dr(32, 128'h0);
      check(d[31:0], `ID_CODE);
    end
  endtask

  task t_bypass;
    begin
      ld_ir(`INS_BYPASS);
      dr(8, 128'hb5);
      check(d[7:0], 8'h6a);
    end
  endtask

  task t_extest;
    begin
      ld_ir(`INS_SAMPLE);
      dr(`BSR_LEN, {19'h0, PRE});
      check(d[`BSR_LEN-1:0], RING);
      check(extest_on, 1'h0);
      ld_ir(`INS_EXTEST);
      check(extest_on, 1'h1);
      check(pin_out, PRE);
      check(q_oe, 1'h0);
      dr(`BSR_LEN, {19'h0, PRE});
      check(d[`BSR_LEN-1:0], RING);
    end
  endtask

  task t_samplez;
    begin
      ld_ir(`INS_SAMPLE_Z);
      check(q_oe, 1'h0);
      check(pin_out, FUNC);
      dr(`BSR_LEN, {19'h0, PRE});
      check(d[`BSR_LEN-1:0], RING);
    end
  endtask

  task t_reset_preset;
    begin
      tap_reset;
      ld_ir(`INS_EXTEST);
      check(q_oe, 1'h1);
      tap_reset;
      dr(32, 128'h0);
      check(d[31:0], `ID_CODE);
    end
  endtask

  // a hung link ends the run with a mismatch
  initial begin
    #1000000;
    fail_count = fail_count + 1;
    summarize;
  end

  // main sequence
  initial begin
    fail_count = 0;
    n_checks   = 0;
    rst_b      = 1'h0;
    ring_in    = RING;
    func_out   = FUNC;
    func_oe    = 1'h1;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge core_clk);
    #3;
    t_power;
    t_bypass;
    t_extest;
    t_samplez;
    t_reset_preset;
    summarize;
  end
endmodule
